// >>> testbench/fsmn_host.sv
// host model driving the same-clock register port of the monitor
`timescale 1ns/1ns
module fsmn_host
(
    // clock and read answer
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    // request to the monitor
    output fsmn_pkg::fsmn_req_t req_o
);
    import fsmn_pkg::*;
    initial req_o = '0; // idle until asked
    // one byte access: driven after an edge, held over one edge, then released
    task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk_i);
        #1 req_o = '{r, !r, a, d};
        @(posedge clk_i);
        #1 req_o = '0;
        q = rdata_i; // answer stands through this cycle
    endtask
endmodule

// >>> testbench/fsmn_top_chk.sv
// port checker for the fault status monitor
`timescale 1ns/1ns
module fsmn_top_chk
(
    // all ports of the monitor, observed only
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire fsmn_pkg::fsmn_fault_t fault_src_i,
    input wire fsmn_pkg::fsmn_cfg_t cfg_sel_i,
    input wire fsmn_pkg::fsmn_req_t reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic fault_any_o
);
    import fsmn_pkg::*;
    logic [2:0] quiet_q; // past cycles without any fault
    logic [2:0] stab_q; // past cycles with steady sources and straps
    wire logic rd = reg_req_i.rd; // read taken this edge
    wire logic [7:0] ad = reg_req_i.addr; // address of the access
    wire logic wclr = reg_req_i.wr && ad == 8'h2D; // write to the clear control
    wire logic wlo = wclr && !reg_req_i.wdata[2]; // clear bit written low
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // input history, so reads are judged only once the synchroniser has caught up
    always_ff @(posedge core_clk_i)
    begin
        quiet_q <= {quiet_q[1:0], fault_src_i == 8'h00};
        stab_q <= {stab_q[1:0], $stable(fault_src_i) && $stable(cfg_sel_i)};
    end
    rvalid_pulse_a: assert property (rd |=> reg_rvalid_o)
        else $error("read answer missing");
    rdata_hold_a: assert property (!rd |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    live_read_a: assert property (rd && ad == 8'h7C && &stab_q && $stable(fault_src_i)
        |=> reg_rdata_o == $past(fault_src_i)) else $error("live flags wrong");
    cfg_read_a: assert property (rd && ad == 8'h75 && &stab_q && $stable(cfg_sel_i)
        |=> reg_rdata_o == {5'h00, $past(cfg_sel_i)}) else $error("config monitor wrong");
    acc_summary_a: assert property (rd && ad == 8'h6D
        |=> (reg_rdata_o != 8'h00) == $past(fault_any_o)) else $error("sticky read wrong");
    sticky_hold_a: assert property (fault_any_o && !wclr && !$past(wclr)
        |=> fault_any_o) else $error("sticky flags lost");
    fault_raise_a: assert property ((|fault_src_i) [*4] |=> fault_any_o)
        else $error("fault not latched");
    clear_empty_a: assert property (wclr && reg_req_i.wdata[2] ##[1:8]
        (wlo && fault_src_i == 8'h00 && &quiet_q) |-> ##[1:3] !fault_any_o)
        else $error("clear toggle ignored");
    unmapped_zero_a: assert property (rd && !(ad inside {8'h2D, 8'h6D, 8'h75, 8'h7C})
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    cover property (rd && ad == 8'h6D && fault_any_o);
    cover property (wlo ##3 !fault_any_o);
    cover property ((|fault_src_i) [*4] ##1 fault_any_o);
endmodule
bind fsmn_top fsmn_top_chk chk (.core_clk_i, .reset_n_i, .fault_src_i, .cfg_sel_i,
    .reg_req_i, .reg_rdata_o, .reg_rvalid_o, .fault_any_o);

// >>> testbench/test_fsmn_top.sv
// self-checking bench for the fault status monitor
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module test_fsmn_top;
    import fsmn_pkg::*;
    logic core_clk_i = 0; // 250 MHz core clock
    logic reset_n_i = 0; // held low at start
    fsmn_fault_t fault_src_i = '0; // protection sources
    fsmn_cfg_t cfg_sel_i = '0; // output stage straps
    fsmn_req_t reg_req_i; // driven by the host model
    logic [7:0] reg_rdata_o, q, acc;
    logic reg_rvalid_o, fault_any_o;
    int errors = 0;
    int compares = 0;
    int seed = 32'hD8E268DD;
    always #2 core_clk_i = ~core_clk_i;
    fsmn_top dut (.core_clk_i, .reset_n_i, .fault_src_i, .cfg_sel_i, .reg_req_i,
        .reg_rdata_o, .reg_rvalid_o, .fault_any_o);
    fsmn_host host (.clk_i(core_clk_i), .rdata_i(reg_rdata_o), .req_o(reg_req_i));
    // sticky image: a bit once seen stays until cleared
    function automatic logic [7:0] acc_exp(input logic [7:0] a, input logic [7:0] f);
        return a | f;
    endfunction
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.xfer(1'b1, a, 8'h00, q);
        `CHK(q, e)
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, q);
    endtask
    task automatic complete_run;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence: reset values, per-source walk, refused writes, clear toggle
    initial
    begin
        acc = 8'h00;
        repeat (4) @(posedge core_clk_i);
        #1 reset_n_i = 1;
        repeat (3) @(posedge core_clk_i);
        rdchk(8'h6D, 8'h00);
        rdchk(8'h7C, 8'h00);
        rdchk(8'h75, 8'h00);
        rdchk(8'h2D, 8'h30);
        rdchk(8'h50, 8'h00);
        // one-hot sources first so each bit position is pinned, then random mixes
        for (int i = 0; i < 16; i++)
        begin
            @(posedge core_clk_i);
            #1 fault_src_i = (i < 8) ? (8'h01 << i) : 8'($random(seed));
            cfg_sel_i = 3'($random(seed));
            repeat (4) @(posedge core_clk_i);
            acc = acc_exp(acc, fault_src_i);
            rdchk(8'h7C, fault_src_i);
            rdchk(8'h75, {5'h00, cfg_sel_i});
            rdchk(8'h6D, acc);
            fault_src_i = '0;
            repeat (4) @(posedge core_clk_i);
            rdchk(8'h7C, 8'h00);
            rdchk(8'h6D, acc);
        end
        wr(8'h6D, 8'h00);
        wr(8'h7C, 8'hFF);
        wr(8'h75, 8'hFF);
        rdchk(8'h6D, acc);
        rdchk(8'h7C, 8'h00);
        rdchk(8'h75, {5'h00, cfg_sel_i});
        // raising the clear bit alone must leave the sticky flags alone
        wr(8'h2D, 8'h34);
        rdchk(8'h6D, acc);
        wr(8'h2D, 8'h30);
        repeat (2) @(posedge core_clk_i);
        rdchk(8'h6D, 8'h00);
        `CHK(fault_any_o, 1'b0)
        complete_run();
    end
    // watchdog, well beyond the few hundred cycles the sequence needs
    initial
    begin
        #40000;
        errors++;
        complete_run();
    end
endmodule

// >>> verilog/fsmn_pkg.sv
// package of constants and carrier types for the fault status monitor
package fsmn_pkg;

    // register bus geometry
    localparam int unsigned FSMN_ADDR_W = 8;
    localparam int unsigned FSMN_DATA_W = 8;
    localparam int unsigned FSMN_CFG_W = 3;

    // register offsets on the serial control register space
    localparam logic [7:0] FSMN_OFS_LATCH_CLEAR = 8'h2D;
    localparam logic [7:0] FSMN_OFS_ACC_FAULT = 8'h6D;
    localparam logic [7:0] FSMN_OFS_CFG_MON = 8'h75;
    localparam logic [7:0] FSMN_OFS_LIVE_FAULT = 8'h7C;

    // values after reset
    localparam logic [7:0] FSMN_RST_LATCH_CLEAR = 8'h30;
    localparam logic [7:0] FSMN_RST_ACC_FAULT = 8'h00;
    localparam logic [7:0] FSMN_RST_CFG_MON = 8'h00;
    localparam logic [7:0] FSMN_RST_LIVE_FAULT = 8'h00;
    localparam logic [7:0] FSMN_UNMAPPED_DATA = 8'h00;

    // field position of the clear control inside its register
    localparam int unsigned FSMN_LATCH_CLEAR_BIT = 2;

    // fault bit positions, shared by live and accumulated vectors
    localparam int unsigned FSMN_BIT_FLYCAP_OV = 0;
    localparam int unsigned FSMN_BIT_OVERCURRENT = 1;
    localparam int unsigned FSMN_BIT_PLL = 2;
    localparam int unsigned FSMN_BIT_SUPPLY_UV = 3;
    localparam int unsigned FSMN_BIT_OT_WARN = 4;
    localparam int unsigned FSMN_BIT_OT_ERR = 5;
    localparam int unsigned FSMN_BIT_PIN_SHORT = 6;
    localparam int unsigned FSMN_BIT_DC_PROT = 7;

    // synchroniser depth in flip-flops
    localparam int unsigned FSMN_SYNC_STAGES = 2;

    // fault vector, msb first so that the packed value matches the register
    typedef struct packed {
        logic dc_prot;      // bit 7
        logic pin_short;    // bit 6
        logic ot_err;       // bit 5
        logic ot_warn;      // bit 4
        logic supply_uv;    // bit 3, power_stage_supply undervoltage
        logic pll;          // bit 2
        logic overcurrent;  // bit 1
        logic flycap_ov;    // bit 0
    } fsmn_fault_t;

    // output stage configuration codes as selected by the straps
    typedef logic [2:0] fsmn_cfg_t;

    // register access request from the serial interface engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fsmn_req_t;

endpackage

// >>> verilog/fsmn_sync.sv
// multi-bit level synchroniser for fault and configuration inputs
`timescale 1ns/1ns
module fsmn_sync #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned STAGES = 2
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    // shift chain; stage 0 is only read by stage 1
    logic [WIDTH-1:0] chain_reg [STAGES];

    // each bit is an independent level, so per-bit skew is harmless here
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            for (int i = 0; i < STAGES; i++)
            begin
                chain_reg[i] <= '0;
            end
        end
        else
        begin
            chain_reg[0] <= async_i;
            for (int i = 1; i < STAGES; i++)
            begin
                chain_reg[i] <= chain_reg[i-1];
            end
        end
    end

    // last stage is the safe copy
    assign sync_o = chain_reg[STAGES-1];

endmodule

// >>> verilog/fsmn_top.sv
// fault status monitor: live and sticky fault registers plus configuration monitor
`timescale 1ns/1ns
module fsmn_top
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // fault sources from the protection circuits, asynchronous levels
    input wire fsmn_pkg::fsmn_fault_t fault_src_i,
    // output stage configuration straps, asynchronous levels
    input wire fsmn_pkg::fsmn_cfg_t cfg_sel_i,
    // register access from the serial interface engine, same clock
    input wire fsmn_pkg::fsmn_req_t reg_req_i,
    // read answer
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // sticky summary for an error pin driver
    output logic fault_any_o
);
    import fsmn_pkg::*;

    // reset release synchroniser
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_n;

    // synchronised sources
    logic [7:0] fault_sync;
    logic [2:0] cfg_sync;

    // register state
    logic [7:0] live_fault_reg;       // live fault flags
    logic [7:0] acc_fault_reg;        // accumulated fault flags
    logic [7:0] acc_fault_next;
    logic [2:0] cfg_mon_reg;          // output configuration monitor
    logic [7:0] latch_clear_reg;      // clear control register image
    logic clear_armed_reg;            // clear bit has been seen high
    logic clear_pulse;                // completed low-high-low toggle
    logic [7:0] rdata_next;
    logic fault_any_reg;
    logic rvalid_reg;

    // read mux decode, shared by the read path
    function automatic logic [7:0] fsmn_read_mux(
        input logic [7:0] addr,
        input logic [7:0] live,
        input logic [7:0] acc,
        input logic [2:0] cfg,
        input logic [7:0] clr
    );
        logic [7:0] res;
        res = FSMN_UNMAPPED_DATA;
        case (addr)
            FSMN_OFS_ACC_FAULT: res = acc;
            FSMN_OFS_LIVE_FAULT: res = live;
            FSMN_OFS_CFG_MON: res = {5'h00, cfg};
            FSMN_OFS_LATCH_CLEAR: res = clr;
            default: res = FSMN_UNMAPPED_DATA;
        endcase
        return res;
    endfunction

    // reset is asserted at once but released only after two clean edges
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    // fault sources come from analog comparators in another timing world
    fsmn_sync #(
        .WIDTH(8),
        .STAGES(FSMN_SYNC_STAGES)
    ) u_fault_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(rst_n),
        .async_i(fault_src_i),
        .sync_o(fault_sync)
    );

    // configuration straps are static but still pass the chain
    fsmn_sync #(
        .WIDTH(3),
        .STAGES(FSMN_SYNC_STAGES)
    ) u_cfg_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(rst_n),
        .async_i(cfg_sel_i),
        .sync_o(cfg_sync)
    );

    // live flags follow the sources, no latching at all
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            live_fault_reg <= FSMN_RST_LIVE_FAULT;
        end
        else
        begin
            live_fault_reg <= fault_sync;
        end
    end

    // configuration monitor simply mirrors the selected output stage mode
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_mon_reg <= FSMN_RST_CFG_MON[2:0];
        end
        else
        begin
            cfg_mon_reg <= cfg_sync;
        end
    end

    // clear control register is the only writable location here
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            latch_clear_reg <= FSMN_RST_LATCH_CLEAR;
        end
        else if (reg_req_i.wr && reg_req_i.addr == FSMN_OFS_LATCH_CLEAR)
        begin
            latch_clear_reg <= reg_req_i.wdata;
        end
        // writes to the monitor offsets fall through and are dropped
    end

    // arm on the bit going high, fire when it returns low
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clear_armed_reg <= 1'b0;
        end
        else if (latch_clear_reg[FSMN_LATCH_CLEAR_BIT])
        begin
            clear_armed_reg <= 1'b1;
        end
        else
        begin
            clear_armed_reg <= 1'b0;
        end
    end

    // a write of high alone never clears; the falling half completes it
    assign clear_pulse = clear_armed_reg && !latch_clear_reg[FSMN_LATCH_CLEAR_BIT];

    // sticky accumulation; a fault present in the clear cycle survives
    always_comb
    begin
        if (clear_pulse)
        begin
            acc_fault_next = fault_sync;
        end
        else
        begin
            acc_fault_next = acc_fault_reg | fault_sync;
        end
    end

    // accumulated flags; host writes never reach this register
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_fault_reg <= FSMN_RST_ACC_FAULT;
        end
        else
        begin
            acc_fault_reg <= acc_fault_next;
        end
    end

    // summary flag for a fault pin, taken from the sticky vector
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_any_reg <= 1'b0;
        end
        else
        begin
            fault_any_reg <= |acc_fault_next;
        end
    end

    // read data picked from registered state, so the answer is one cycle late
    assign rdata_next = fsmn_read_mux(reg_req_i.addr, live_fault_reg, acc_fault_reg,
                                      cfg_mon_reg, latch_clear_reg);

    // read answer register
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata_o <= 8'h00;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= reg_req_i.rd;
            if (reg_req_i.rd)
            begin
                reg_rdata_o <= rdata_next;
            end
        end
    end

    assign reg_rvalid_o = rvalid_reg;
    assign fault_any_o = fault_any_reg;

endmodule
